//--- shared/uic_map.svh
// register offsets, field positions, reset values and codes of the control block
`ifndef UIC_MAP_SVH
`define UIC_MAP_SVH

`define UIC_OFS_DATA 3'h0
`define UIC_OFS_MASK 3'h1
`define UIC_OFS_SRC 3'h2
`define UIC_OFS_LINE 3'h3
`define UIC_OFS_MODEM 3'h4
`define UIC_OFS_LSTATE 3'h5
`define UIC_OFS_MSTATE 3'h6
`define UIC_OFS_SCRATCH 3'h7

`define UIC_MASK_RX 0
`define UIC_MASK_TX 1
`define UIC_MASK_LINE 2
`define UIC_MASK_MODEM 3
`define UIC_FCR_EN 0
`define UIC_FCR_RXRST 1
`define UIC_FCR_TXRST 2
`define UIC_FCR_DMA 3
`define UIC_FCR_TRIG_HI 7
`define UIC_FCR_TRIG_LO 6
`define UIC_LCR_DIV 7
`define UIC_MCR_DTR 0
`define UIC_MCR_RTS 1

`define UIC_RST_MASK 4'h0
`define UIC_RST_LINE 8'h00
`define UIC_RST_MODEM 5'h00
`define UIC_RST_SCRATCH 8'hFF
`define UIC_RST_DIV 8'h00

`define UIC_TRIG_1 5'h01
`define UIC_TRIG_4 5'h04
`define UIC_TRIG_8 5'h08
`define UIC_TRIG_14 5'h0E

`define UIC_TO_CHARS 4
`define UIC_TO_BITS 12
`define UIC_START_BITS 1
`define UIC_BASE_WORD 5

`endif

//--- shared/uic_pkg.sv
// types shared by the serial channel control block
`default_nettype none
package uic_pkg;

  typedef enum logic [3:0] {
    UIC_SRC_LINE = 4'h6,
    UIC_SRC_TIMEOUT = 4'hC,
    UIC_SRC_RXDATA = 4'h4,
    UIC_SRC_TXREADY = 4'h2,
    UIC_SRC_MODEM = 4'h0,
    UIC_SRC_NONE = 4'h1
  } uic_src_t;

  typedef struct packed {
    logic div_access;
    logic brk;
    logic stick;
    logic even;
    logic parity_en;
    logic long_stop;
    logic [1:0] word_len;
  } uic_fmt_t;

  typedef struct packed {
    logic loop_en;
    logic out2;
    logic out1;
    logic rts;
    logic dtr;
  } uic_mcr_t;

endpackage
`default_nettype wire

//--- rtl/uic_ctrl.sv
// interrupt, fifo control, line format and modem output control of one channel
//
// What this block does
// - mask bit 3 enables the modem status interrupt; off at reset; 7:4 reserved.
// - source read reports only the highest pending interrupt; others stay queued.
// - codes: line 0110, timeout 1100, rx data 0100, tx 0010, modem 0000, none 0001.
// - line interrupt raised by line status bits 1-4; cleared by line status read.
// - rx data interrupt while receive fill is at or above trigger level.
// - timeout after four characters plus twelve bits idle; cleared by rx read.
// - tx ready raised by tx trigger or tx empty; cleared by a source read that reports it, or by tx write.
// - modem interrupt raised by modem status bits 0-3; cleared by modem status read.
// - source bit 0 reads 0 while any unmasked interrupt is pending, 1 otherwise; resets to 1.
// - source bits 7:6 read 1 while fifos enabled, else 0; 5:4 read 0.
// - fifo control bit 0 enables fifos and must be 1 for other bits to apply.
// - fifo reset bits clear pointers of that fifo only, then self-clear.
// - fifo control bit 3 selects dma mode for the dma request pins.
// - trigger bits 7:6 select 1, 4, 8 or 14 characters; 5:4 reserved.
// - line format bits 1:0 select 5, 6, 7 or 8 data bits.
// - bit 2 gives 1.5 stop bits with 5-bit words, else 2 stop bits.
// - bit 3 adds a parity bit on transmit and checks it on receive.
// - bit 4 selects odd (0) or even (1) parity when not forced.
// - bit 5 forces parity to 1 when bit 4 is 0, to 0 when bit 4 is 1.
// - bit 6 holds the transmit output at space until it is cleared.
// - bit 7 maps the low addresses to the divisor latches.
// - modem control bits 0 and 1 drive terminal-ready and send-request low.
// - mask bit 1 enables the tx ready interrupt raised when the tx fifo empties.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "uic_map.svh"

module uic_ctrl #(
  parameter int FIFO_DEPTH = 16,
  parameter int FILL_W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic bit_tick,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic rx_push,
  input wire logic [7:0] rx_data,
  input wire logic [FILL_W-1:0] tx_fill,
  input wire logic tx_trigger,
  input wire logic [7:0] line_state_reg,
  input wire logic [7:0] modem_state_reg,
  input wire logic tx_serial,
  output logic tx_line,
  output logic rx_pop,
  output logic tx_load,
  output logic [7:0] tx_data,
  output logic line_state_read,
  output logic modem_state_read,
  output logic rx_fifo_clear,
  output logic tx_fifo_clear,
  output logic fifo_enable,
  output uic_pkg::uic_fmt_t line_format,
  output uic_pkg::uic_mcr_t modem_ctrl,
  output logic [15:0] divisor,
  output logic terminal_ready_n,
  output logic send_request_n,
  output logic tx_dma_request_n,
  output logic rx_dma_request_n
);

  // trigger decode is needed by both the interrupt and the dma pin
  function automatic logic [FILL_W-1:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = FILL_W'(`UIC_TRIG_1);
      2'h1: trig_level = FILL_W'(`UIC_TRIG_4);
      2'h2: trig_level = FILL_W'(`UIC_TRIG_8);
      default: trig_level = FILL_W'(`UIC_TRIG_14);
    endcase
  endfunction

  // bits in one character: start, data, parity, stop (1.5 counts as 2)
  function automatic logic [5:0] char_bits(input uic_pkg::uic_fmt_t f);
    char_bits = 6'(`UIC_START_BITS) + 6'(`UIC_BASE_WORD) + {4'h0, f.word_len}
      + {5'h00, f.parity_en} + 6'h01 + {5'h00, f.long_stop};
  endfunction

  logic [3:0] mask_reg, mask_next;
  uic_pkg::uic_fmt_t line_format_reg, line_format_next;
  uic_pkg::uic_mcr_t modem_out_reg, modem_out_next;
  logic [7:0] div_lo_reg, div_lo_next, divisor_high, divisor_high_next;
  logic [7:0] scratch_reg, scratch_next;
  logic fifo_en_reg, fifo_en_next, dma_reg, dma_next;
  logic [1:0] trig_reg, trig_next;
  logic line_pend_reg, line_pend_next, modem_pend_reg, modem_pend_next;
  logic tx_pend_reg, tx_pend_next, to_pend_reg, to_pend_next;
  logic line_any_reg, modem_any_reg, tx_empty_reg;
  logic [5:0] to_cnt_reg, to_cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next, tx_line_reg, tx_line_next;
  logic rx_pop_reg, tx_load_reg, ls_rd_reg, ms_rd_reg;
  logic rx_clr_reg, rx_clr_next, tx_clr_reg, tx_clr_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic txdma_n_reg, txdma_n_next, rxdma_n_reg, rxdma_n_next;
  logic [1:0] modem_pin_n_reg, modem_pin_n_next;

  logic line_any, modem_any, tx_empty, rx_level, divsel;
  logic rd_data, wr_data, rd_src, rd_line, rd_modem;
  uic_pkg::uic_src_t src;
  logic [7:0] src_byte;
  logic [5:0] to_limit;

  always_comb begin
    line_any = |line_state_reg[4:1];
    modem_any = |modem_state_reg[3:0];
    tx_empty = (tx_fill == '0);
    rx_level = (rx_fill >= trig_level(trig_reg));
    divsel = line_format_reg.div_access;
    rd_data = rd && addr == `UIC_OFS_DATA && !divsel;
    wr_data = wr && addr == `UIC_OFS_DATA && !divsel;
    rd_src = rd && addr == `UIC_OFS_SRC;
    rd_line = rd && addr == `UIC_OFS_LSTATE;
    rd_modem = rd && addr == `UIC_OFS_MSTATE;
    to_limit = 6'(`UIC_TO_CHARS * char_bits(line_format_reg)
      + `UIC_TO_BITS);
    // fixed priority; lower ones wait until the higher one is serviced
    if (line_pend_reg && mask_reg[`UIC_MASK_LINE]) begin
      src = uic_pkg::UIC_SRC_LINE;
    end else if (to_pend_reg && mask_reg[`UIC_MASK_RX]) begin
      src = uic_pkg::UIC_SRC_TIMEOUT;
    end else if (rx_level && mask_reg[`UIC_MASK_RX]) begin
      src = uic_pkg::UIC_SRC_RXDATA;
    end else if (tx_pend_reg && mask_reg[`UIC_MASK_TX]) begin
      src = uic_pkg::UIC_SRC_TXREADY;
    end else if (modem_pend_reg && mask_reg[`UIC_MASK_MODEM]) begin
      src = uic_pkg::UIC_SRC_MODEM;
    end else begin
      src = uic_pkg::UIC_SRC_NONE;
    end
    src_byte = {{2{fifo_en_reg}}, 2'h0, src};
  end

  always_comb begin
    mask_next = mask_reg;
    line_format_next = line_format_reg;
    modem_out_next = modem_out_reg;
    div_lo_next = div_lo_reg;
    divisor_high_next = divisor_high;
    scratch_next = scratch_reg;
    fifo_en_next = fifo_en_reg;
    dma_next = dma_reg;
    trig_next = trig_reg;
    rx_clr_next = 1'b0;
    tx_clr_next = 1'b0;
    tx_data_next = tx_data_reg;
    if (wr) begin
      case (addr)
        `UIC_OFS_DATA: begin
          if (divsel) begin
            div_lo_next = wdata;
          end else begin
            tx_data_next = wdata;
          end
        end
        `UIC_OFS_MASK: begin
          if (divsel) begin
            divisor_high_next = wdata;
          end else begin
            mask_next = wdata[3:0];
          end
        end
        `UIC_OFS_SRC: begin
          fifo_en_next = wdata[`UIC_FCR_EN];
          // other fields ignored unless the enable bit is written as 1
          if (wdata[`UIC_FCR_EN]) begin
            rx_clr_next = wdata[`UIC_FCR_RXRST];
            tx_clr_next = wdata[`UIC_FCR_TXRST];
            dma_next = wdata[`UIC_FCR_DMA];
            trig_next = wdata[`UIC_FCR_TRIG_HI:`UIC_FCR_TRIG_LO];
          end
        end
        `UIC_OFS_LINE: line_format_next = wdata;
        `UIC_OFS_MODEM: modem_out_next = wdata[4:0];
        `UIC_OFS_SCRATCH: scratch_next = wdata;
        default: scratch_next = scratch_reg;
      endcase
    end

    // pending flags: a new event beats a clear in the same cycle
    line_pend_next = line_pend_reg;
    if (rd_line) begin
      line_pend_next = 1'b0;
    end
    if (line_any && !line_any_reg) begin
      line_pend_next = 1'b1;
    end
    modem_pend_next = modem_pend_reg;
    if (rd_modem) begin
      modem_pend_next = 1'b0;
    end
    if (modem_any && !modem_any_reg) begin
      modem_pend_next = 1'b1;
    end
    tx_pend_next = tx_pend_reg;
    if (wr_data || (rd_src && src == uic_pkg::UIC_SRC_TXREADY)) begin
      tx_pend_next = 1'b0;
    end
    if (tx_trigger || (tx_empty && !tx_empty_reg)) begin
      tx_pend_next = 1'b1;
    end

    // idle timer restarts on each received or read character
    to_cnt_next = to_cnt_reg;
    to_pend_next = to_pend_reg;
    if (rx_push || rd_data || rx_fill == '0) begin
      to_cnt_next = 6'h00;
    end else if (bit_tick && !to_pend_reg) begin
      if (to_cnt_reg + 6'h01 >= to_limit) begin
        to_pend_next = 1'b1;
        to_cnt_next = 6'h00;
      end else begin
        to_cnt_next = to_cnt_reg + 6'h01;
      end
    end
    if (rd_data) begin
      to_pend_next = 1'b0;
    end

    rdata_next = rdata_reg;
    if (rd) begin
      case (addr)
        `UIC_OFS_DATA: rdata_next = divsel ? div_lo_reg : rx_data;
        `UIC_OFS_MASK: rdata_next = divsel ? divisor_high : {4'h0, mask_reg};
        `UIC_OFS_SRC: rdata_next = src_byte;
        `UIC_OFS_LINE: rdata_next = line_format_reg;
        `UIC_OFS_MODEM: rdata_next = {3'h0, modem_out_reg};
        `UIC_OFS_LSTATE: rdata_next = line_state_reg;
        `UIC_OFS_MSTATE: rdata_next = modem_state_reg;
        default: rdata_next = scratch_reg;
      endcase
    end

    irq_next = (src != uic_pkg::UIC_SRC_NONE);
    tx_line_next = tx_serial && !line_format_reg.brk;
    // inverted drive: a set control bit pulls the pin low
    modem_pin_n_next = ~{modem_out_next.rts, modem_out_next.dtr};
    // normal mode: single character handshake; dma mode: block by level
    if (dma_reg) begin
      rxdma_n_next = !(rx_level || to_pend_reg);
      txdma_n_next = !(tx_fill < FILL_W'(FIFO_DEPTH));
    end else begin
      rxdma_n_next = (rx_fill == '0);
      txdma_n_next = !tx_empty;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= `UIC_RST_MASK;
      line_format_reg <= `UIC_RST_LINE;
      modem_out_reg <= `UIC_RST_MODEM;
      div_lo_reg <= `UIC_RST_DIV;
      divisor_high <= `UIC_RST_DIV;
      scratch_reg <= `UIC_RST_SCRATCH;
      fifo_en_reg <= 1'b0;
      dma_reg <= 1'b0;
      trig_reg <= 2'h0;
      line_pend_reg <= 1'b0;
      modem_pend_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      to_pend_reg <= 1'b0;
      line_any_reg <= 1'b0;
      modem_any_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      to_cnt_reg <= 6'h00;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      rx_pop_reg <= 1'b0;
      tx_load_reg <= 1'b0;
      ls_rd_reg <= 1'b0;
      ms_rd_reg <= 1'b0;
      rx_clr_reg <= 1'b0;
      tx_clr_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      txdma_n_reg <= 1'b1;
      rxdma_n_reg <= 1'b1;
      modem_pin_n_reg <= 2'h3;
    end else begin
      mask_reg <= mask_next;
      line_format_reg <= line_format_next;
      modem_out_reg <= modem_out_next;
      div_lo_reg <= div_lo_next;
      divisor_high <= divisor_high_next;
      scratch_reg <= scratch_next;
      fifo_en_reg <= fifo_en_next;
      dma_reg <= dma_next;
      trig_reg <= trig_next;
      line_pend_reg <= line_pend_next;
      modem_pend_reg <= modem_pend_next;
      tx_pend_reg <= tx_pend_next;
      to_pend_reg <= to_pend_next;
      line_any_reg <= line_any;
      modem_any_reg <= modem_any;
      tx_empty_reg <= tx_empty;
      to_cnt_reg <= to_cnt_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      tx_line_reg <= tx_line_next;
      rx_pop_reg <= rd_data;
      tx_load_reg <= wr_data;
      ls_rd_reg <= rd_line;
      ms_rd_reg <= rd_modem;
      rx_clr_reg <= rx_clr_next;
      tx_clr_reg <= tx_clr_next;
      tx_data_reg <= tx_data_next;
      txdma_n_reg <= txdma_n_next;
      rxdma_n_reg <= rxdma_n_next;
      modem_pin_n_reg <= modem_pin_n_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign tx_line = tx_line_reg;
  assign rx_pop = rx_pop_reg;
  assign tx_load = tx_load_reg;
  assign tx_data = tx_data_reg;
  assign line_state_read = ls_rd_reg;
  assign modem_state_read = ms_rd_reg;
  assign rx_fifo_clear = rx_clr_reg;
  assign tx_fifo_clear = tx_clr_reg;
  assign fifo_enable = fifo_en_reg;
  assign line_format = line_format_reg;
  assign modem_ctrl = modem_out_reg;
  assign divisor = {divisor_high, div_lo_reg};
  assign terminal_ready_n = modem_pin_n_reg[0];
  assign send_request_n = modem_pin_n_reg[1];
  assign tx_dma_request_n = txdma_n_reg;
  assign rx_dma_request_n = rxdma_n_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_src_line_first: assert property (
    rd_src && line_pend_reg && mask_reg[`UIC_MASK_LINE]
      |=> rdata[3:0] == 4'h6)
    else $error("line status not reported first");
  a_src_none_code: assert property (
    rd_src && !irq_next |=> rdata[0] && rdata[3:1] == 3'h0)
    else $error("idle source code wrong");
  a_src_fifo_bits: assert property (
    rd_src |=> rdata[7:6] == {2{$past(fifo_en_reg)}} && rdata[5:4] == 2'h0)
    else $error("fifo status bits wrong");
  a_fcr_needs_en: assert property (
    wr && addr == `UIC_OFS_SRC && !wdata[0] |=> $stable(trig_reg)
      && $stable(dma_reg) && !rx_fifo_clear && !tx_fifo_clear)
    else $error("fifo control applied without enable");
  a_rx_clear_pulse: assert property (
    rx_fifo_clear |=> !rx_fifo_clear)
    else $error("fifo reset did not self clear");
  a_break_space: assert property (
    line_format_reg.brk [*2] |-> !tx_line)
    else $error("break not driving space");
  a_line_clear_rd: assert property (
    rd_line && !(line_any && !line_any_reg) |=> !line_pend_reg)
    else $error("line interrupt not cleared by read");
  a_tx_clear_wr: assert property (
    wr_data && !tx_trigger && !(tx_empty && !tx_empty_reg) |=> !tx_pend_reg)
    else $error("tx ready not cleared by write");
  a_modem_masked: assert property (
    rd_src && !mask_reg[`UIC_MASK_MODEM] |=> rdata[3:0] != 4'h0)
    else $error("modem interrupt passed while masked");
  a_dtr_pin: assert property (
    $rose(modem_out_reg.dtr) |-> !terminal_ready_n)
    else $error("terminal ready not driven low");
  a_rx_level_irq: assert property (
    mask_reg[`UIC_MASK_RX] && rx_level |=> irq)
    else $error("rx level interrupt missing");

endmodule // uic_ctrl
`default_nettype wire

//--- test/uic_far_model.sv
// far-side model of the control block: fifo fills, status flags, bit timing
`timescale 1ns/1ps
`default_nettype none

module uic_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic line_err,
  input wire logic modem_delta,
  input wire logic rx_pop,
  input wire logic tx_load,
  input wire logic rx_fifo_clear,
  input wire logic tx_fifo_clear,
  input wire logic line_state_read,
  input wire logic modem_state_read,
  output logic bit_tick,
  output logic rx_push,
  output logic [4:0] rx_fill,
  output logic [4:0] tx_fill,
  output logic [7:0] rx_data,
  output logic [7:0] line_state_reg,
  output logic [7:0] modem_state_reg,
  output logic tx_serial
);
  logic [1:0] div_cnt;
  logic overrun;
  logic delta;

  // four clocks per bit keeps the timeout spans short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
      bit_tick <= 1'h0;
      rx_push <= 1'h0;
      rx_fill <= 5'h00;
      tx_fill <= 5'h00;
      overrun <= 1'h0;
      delta <= 1'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
      bit_tick <= (div_cnt == 2'h3);
      rx_push <= push;
      if (rx_fifo_clear) begin
        rx_fill <= 5'h00;
      end else begin
        rx_fill <= rx_fill + {4'h0, push} - {4'h0, rx_pop};
      end
      // the transmitter is stalled: the tx fifo empties only by a clear
      if (tx_fifo_clear) begin
        tx_fill <= 5'h00;
      end else if (tx_load && tx_fill != 5'h10) begin
        tx_fill <= tx_fill + 5'h01;
      end
      overrun <= line_err | (overrun & ~line_state_read);
      delta <= modem_delta | (delta & ~modem_state_read);
    end
  end

  assign rx_data = {3'h5, rx_fill};
  assign line_state_reg = {6'h00, overrun, rx_fill != 5'h00};
  assign modem_state_reg = {7'h00, delta};
  assign tx_serial = div_cnt[1];
endmodule // uic_far_model
`default_nettype wire

//--- test/tb_uart_irq_fifo_line_control.sv
// self-checking bench of the channel control block
`timescale 1ns/1ps
`default_nettype none
`include "uic_map.svh"

module tb_uart_irq_fifo_line_control;
  logic clk, rst_n, wr, rd, tx_trigger, push, line_err, modem_delta;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, tx_data, rx_data, v;
  logic irq, bit_tick, rx_push, tx_line, rx_pop, tx_load, tx_serial;
  logic line_state_read, modem_state_read, rx_fifo_clear, tx_fifo_clear;
  logic fifo_enable, terminal_ready_n, send_request_n;
  logic tx_dma_request_n, rx_dma_request_n;
  logic [4:0] rx_fill, tx_fill;
  logic [7:0] line_state_reg, modem_state_reg;
  logic [15:0] divisor;
  uic_pkg::uic_fmt_t line_format;
  uic_pkg::uic_mcr_t modem_ctrl;
  int errors, n_compared, seed, n, lvl;
  localparam logic [10:0] PRIO [9] = '{
    {`UIC_OFS_SRC, 8'hC6}, {`UIC_OFS_SRC, 8'hC6}, {`UIC_OFS_LSTATE, 8'h03},
    {`UIC_OFS_SRC, 8'hC4}, {`UIC_OFS_DATA, 8'hA1}, {`UIC_OFS_SRC, 8'hC2},
    {`UIC_OFS_SRC, 8'hC0}, {`UIC_OFS_MSTATE, 8'h01}, {`UIC_OFS_SRC, 8'hC1}};

  uic_ctrl uut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .irq,
    .bit_tick, .rx_fill, .rx_push, .rx_data, .tx_fill, .tx_trigger,
    .line_state_reg, .modem_state_reg, .tx_serial, .tx_line, .rx_pop,
    .tx_load, .tx_data, .line_state_read, .modem_state_read,
    .rx_fifo_clear, .tx_fifo_clear, .fifo_enable, .line_format,
    .modem_ctrl, .divisor, .terminal_ready_n, .send_request_n,
    .tx_dma_request_n, .rx_dma_request_n);

  uic_far_model far (.clk, .rst_n, .push, .line_err, .modem_delta,
    .rx_pop, .tx_load, .rx_fifo_clear, .tx_fifo_clear, .line_state_read,
    .modem_state_read, .bit_tick, .rx_push, .rx_fill, .tx_fill, .rx_data,
    .line_state_reg, .modem_state_reg, .tx_serial);

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  function automatic int trig_level(input int k);
    return (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14;
  endfunction

  // 1.5 stop bits count as two, as the timer rounds up
  function automatic int timeout_ticks(input logic [7:0] f);
    return 4 * (6 + int'(f[1:0]) + int'(f[3]) + (f[2] ? 2 : 1)) + 12;
  endfunction

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // the gap lets registered fills and flags land before the read
  task automatic rd_chk(input string what, input logic [2:0] a,
                        input logic [7:0] exp);
    repeat (2) @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 check(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic push_n(input int k);
    repeat (k) begin
      @(posedge clk);
      push <= 1'h1;
      @(posedge clk);
      push <= 1'h0;
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // the whole sequence needs some 820 clocks
  initial begin
    #100000;
    errors++;
    tally_and_finish();
  end

  initial begin
    seed = 75;
    errors = 0;
    n_compared = 0;
    rst_n = 1'h0;
    {wr, rd, tx_trigger, push, line_err, modem_delta} = 6'h00;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (5) @(posedge clk);
    check("reset pins", 16'h003B, {10'h000, tx_line, terminal_ready_n,
          send_request_n, fifo_enable, rx_dma_request_n, tx_dma_request_n});
    check("reset fmt", 16'h0000, {8'h00, line_format} | divisor);
    rst_n <= 1'h1;
    rd_chk("src reset", `UIC_OFS_SRC, 8'h01);
    wr_reg(`UIC_OFS_MASK, 8'hFF);
    rd_chk("mask", `UIC_OFS_MASK, 8'h0F);
    wr_reg(`UIC_OFS_MASK, 8'h00);
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'h40 : (i == 1) ? 8'h7F : 8'($random(seed)) & 8'h7F;
      wr_reg(`UIC_OFS_LINE, v);
      settle();
      check("format", {8'h00, v}, {8'h00, line_format});
      if (v[6]) check("break", 16'h0000, {15'h0000, tx_line});
      rd_chk("format rd", `UIC_OFS_LINE, v);
    end
    for (int i = 0; i < 4; i++) begin
      wr_reg(`UIC_OFS_MODEM, 8'(i));
      settle();
      check("ready pins", {14'h0000, ~i[1:0]},
            {14'h0000, send_request_n, terminal_ready_n});
    end
    wr_reg(`UIC_OFS_MODEM, 8'hFF);
    #1 check("modem ctrl", 16'h001F, {11'h000, modem_ctrl});
    rd_chk("modem rd", `UIC_OFS_MODEM, 8'h1F);
    wr_reg(`UIC_OFS_MODEM, 8'h00);
    wr_reg(`UIC_OFS_LINE, 8'h83);
    wr_reg(`UIC_OFS_DATA, 8'h34);
    wr_reg(`UIC_OFS_MASK, 8'h12);
    settle();
    check("divisor", 16'h1234, divisor);
    rd_chk("div high", `UIC_OFS_MASK, 8'h12);
    wr_reg(`UIC_OFS_LINE, 8'h03);
    rd_chk("mask back", `UIC_OFS_MASK, 8'h00);
    wr_reg(`UIC_OFS_DATA, 8'h5A);
    #1 check("tx load", 16'h015A, {7'h00, tx_load, tx_data});
    wr_reg(`UIC_OFS_SRC, 8'h01);
    #1 check("fifo en", 16'h0001, {15'h0000, fifo_enable});
    rd_chk("fifo on", `UIC_OFS_SRC, 8'hC1);
    wr_reg(`UIC_OFS_SRC, 8'h06);
    #1 check("no clear", 16'h0000, {14'h0000, rx_fifo_clear,
             tx_fifo_clear});
    rd_chk("fifo off", `UIC_OFS_SRC, 8'h01);
    wr_reg(`UIC_OFS_SRC, 8'h07);
    #1 check("clears", 16'h0003, {14'h0000, rx_fifo_clear,
             tx_fifo_clear});
    wr_reg(`UIC_OFS_MASK, 8'h01);
    for (int k = 0; k < 4; k++) begin
      lvl = trig_level(k);
      wr_reg(`UIC_OFS_SRC, {2'(k), 6'h03});
      push_n(lvl - 1);
      rd_chk("below trig", `UIC_OFS_SRC, 8'hC1);
      push_n(1);
      rd_chk("at trig", `UIC_OFS_SRC, 8'hC4);
      check("irq on", 16'h0001, {15'h0000, irq});
      rd_chk("rx byte", `UIC_OFS_DATA, {3'h5, 5'(lvl)});
      check("rx pop", 16'h0001, {15'h0000, rx_pop});
      rd_chk("drained", `UIC_OFS_SRC, 8'hC1);
    end
    wr_reg(`UIC_OFS_SRC, 8'h03);
    wr_reg(`UIC_OFS_MASK, 8'h0F);
    push_n(1);
    @(posedge clk);
    {line_err, modem_delta, tx_trigger} <= 3'h7;
    @(posedge clk);
    {line_err, modem_delta, tx_trigger} <= 3'h0;
    foreach (PRIO[j]) begin
      rd_chk("priority", PRIO[j][10:8], PRIO[j][7:0]);
    end
    settle();
    check("irq off", 16'h0000, {15'h0000, irq});
    rd_chk("line idle", `UIC_OFS_LSTATE, 8'h00);
    check("line read", 16'h0001, {15'h0000, line_state_read});
    rd_chk("modem idle", `UIC_OFS_MSTATE, 8'h00);
    check("modem read", 16'h0001, {15'h0000, modem_state_read});
    @(posedge clk);
    tx_trigger <= 1'h1;
    @(posedge clk);
    tx_trigger <= 1'h0;
    wr_reg(`UIC_OFS_DATA, 8'hA5);
    rd_chk("tx write clr", `UIC_OFS_SRC, 8'hC1);
    wr_reg(`UIC_OFS_MASK, 8'h01);
    for (int f = 0; f < 2; f++) begin
      v = f ? 8'h0F : 8'h04;
      n = timeout_ticks(v);
      wr_reg(`UIC_OFS_LINE, v);
      wr_reg(`UIC_OFS_SRC, 8'hC3);
      push_n(1);
      repeat (4 * (n - 4)) @(posedge clk);
      rd_chk("no timeout", `UIC_OFS_SRC, 8'hC1);
      repeat (32) @(posedge clk);
      rd_chk("timeout", `UIC_OFS_SRC, 8'hCC);
      rd_chk("rx byte", `UIC_OFS_DATA, 8'hA1);
      rd_chk("timeout clr", `UIC_OFS_SRC, 8'hC1);
    end
    wr_reg(`UIC_OFS_SRC, 8'hC3);
    push_n(2);
    settle();
    check("dma normal", 16'h0001, {14'h0000, rx_dma_request_n,
          tx_dma_request_n});
    wr_reg(`UIC_OFS_SRC, 8'hC9);
    settle();
    check("dma mode", 16'h0002, {14'h0000, rx_dma_request_n,
          tx_dma_request_n});
    push_n(12);
    settle();
    check("dma trig", 16'h0000, {15'h0000, rx_dma_request_n});
    tally_and_finish();
  end
endmodule // tb_uart_irq_fifo_line_control
`default_nettype wire
